// ---- xbs_crossbar_switch.sv ----
// Four-master, three-slave crossbar switch with one arbiter per slave.
// Assumes masters hold a request stable until they see their ready pulse,
// and slaves answer a held request with a one-cycle ready pulse.
//
// Operation
// - Four master ports reach three slave ports over independent paths.
// - Every port carries a 32-bit address and 64-bit data.
// - Up to three transfers may run at once on distinct paths, one of them an instruction fetch from flash.
// - When masters contend for a slave in fixed mode the higher priority master wins.
// - Losing masters stall with their request pending until the winner is done.
// - Round-robin mode grants from the master after the last one granted.
// - A fixed priority order set at run time governs later decisions.
// - A master may be raised in priority for a while and then falls back.
// - Masters are instruction unit, data unit, DMA controller and network controller.
// - Slaves are the flash controller, the SRAM controller and the peripheral bridge.
// - Each processing channel has its own instance with no shared arbitration state.
`timescale 1ns/1ps
module xbs_crossbar_switch
  import xbs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Arbitration control.
  input wire logic rrMode,
  input wire logic [XBS_NUM_M-1:0][1:0] mPrio,
  input wire logic [XBS_NUM_M-1:0] mElevate,
  // Master ports.
  input wire logic [XBS_NUM_M-1:0] mReq,
  input wire logic [XBS_NUM_M-1:0][XBS_ADDR_W-1:0] mAddr,
  input wire logic [XBS_NUM_M-1:0] mWrite,
  input wire logic [XBS_NUM_M-1:0][XBS_DATA_W-1:0] mWdata,
  input wire logic [XBS_NUM_M-1:0] mLock,
  output logic [XBS_NUM_M-1:0] mReady,
  output logic [XBS_NUM_M-1:0][XBS_DATA_W-1:0] mRdata,
  // Slave ports.
  output logic [XBS_NUM_S-1:0] sReq,
  output logic [XBS_NUM_S-1:0][XBS_ADDR_W-1:0] sAddr,
  output logic [XBS_NUM_S-1:0] sWrite,
  output logic [XBS_NUM_S-1:0][XBS_DATA_W-1:0] sWdata,
  input wire logic [XBS_NUM_S-1:0] sReady,
  input wire logic [XBS_NUM_S-1:0][XBS_DATA_W-1:0] sRdata
);
  // All arbitration state lives here, so two instances share nothing.
  typedef struct packed {
    xbs_slv_state_t [XBS_NUM_S-1:0] st;
    logic [XBS_NUM_S-1:0][1:0] owner;
    logic [XBS_NUM_S-1:0][1:0] lastId;
    logic [XBS_NUM_S-1:0] held;
    logic [XBS_NUM_S-1:0] sReq;
    logic [XBS_NUM_S-1:0][XBS_ADDR_W-1:0] sAddr;
    logic [XBS_NUM_S-1:0] sWrite;
    logic [XBS_NUM_S-1:0][XBS_DATA_W-1:0] sWdata;
    logic [XBS_NUM_M-1:0] mReady;
    logic [XBS_NUM_M-1:0][XBS_DATA_W-1:0] mRdata;
  } xbs_state_t;

  xbs_state_t state_reg;
  xbs_state_t state_next;
  logic [XBS_NUM_S-1:0][XBS_NUM_M-1:0] reqVec;
  logic [XBS_NUM_S-1:0][1:0] grantId;
  logic [XBS_NUM_S-1:0] grantValid;

  // A master asks only the slave its address decodes to.
  always_comb begin
    for (int s = 0; s < XBS_NUM_S; s++) begin
      for (int m = 0; m < XBS_NUM_M; m++) begin
        reqVec[s][m] = mReq[m] && (xbsDecode(mAddr[m]) == 2'(s));
      end
    end
  end

  xbs_arb_if arbBus[XBS_NUM_S] ();

  // One arbiter per slave port lets every path run at the same time.
  for (genvar s = 0; s < XBS_NUM_S; s++) begin : g_arb
    assign arbBus[s].req = reqVec[s];
    assign arbBus[s].elevate = mElevate;
    assign arbBus[s].prio = mPrio;
    assign arbBus[s].rrMode = rrMode;
    assign arbBus[s].lastId = state_reg.lastId[s];
    assign grantId[s] = arbBus[s].grantId;
    assign grantValid[s] = arbBus[s].grantValid;
    xbs_arbiter u_arb (
      .bus(arbBus[s])
    );
  end

  always_comb begin
    logic [1:0] id;
    id = XBS_RST_ID;
    state_next = state_reg;
    state_next.mReady = '0;
    for (int s = 0; s < XBS_NUM_S; s++) begin
      id = state_reg.owner[s];
      case (state_reg.st[s])
        XBS_IDLE: begin
          if (state_reg.held[s] && reqVec[s][id]) begin
            state_next.st[s] = XBS_ISSUE;
          end else if (grantValid[s]) begin
            id = grantId[s];
            state_next.owner[s] = id;
            state_next.lastId[s] = id;
            state_next.held[s] = 1'b0;
            state_next.st[s] = XBS_ISSUE;
          end else begin
            state_next.held[s] = 1'b0;
          end
          if (state_next.st[s] == XBS_ISSUE) begin
            state_next.sReq[s] = 1'b1;
            state_next.sAddr[s] = mAddr[id];
            state_next.sWrite[s] = mWrite[id];
            state_next.sWdata[s] = mWdata[id];
          end
        end
        XBS_ISSUE: begin
          // Other requesters of this slave wait with ready low.
          if (sReady[s]) begin
            state_next.sReq[s] = 1'b0;
            state_next.mReady[id] = 1'b1;
            state_next.mRdata[id] = sRdata[s];
            state_next.held[s] = mLock[id];
            state_next.st[s] = XBS_RESP;
          end
        end
        XBS_RESP: begin
          // The master still shows the finished request this cycle,
          // so it is not looked at again until the next one.
          state_next.st[s] = XBS_IDLE;
        end
        default: begin
          state_next.st[s] = XBS_IDLE;
          state_next.sReq[s] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < XBS_NUM_S; s++) begin
        state_reg.st[s] <= XBS_IDLE;
        state_reg.owner[s] <= XBS_RST_ID;
        state_reg.lastId[s] <= XBS_RST_ID;
        state_reg.sAddr[s] <= XBS_RST_ADDR;
        state_reg.sWdata[s] <= XBS_RST_DATA;
      end
      state_reg.held <= '0;
      state_reg.sReq <= '0;
      state_reg.sWrite <= '0;
      state_reg.mReady <= '0;
      for (int m = 0; m < XBS_NUM_M; m++) begin
        state_reg.mRdata[m] <= XBS_RST_DATA;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  // Master ids follow the package: instruction, data, DMA, network.
  assign mReady = state_reg.mReady;
  assign mRdata = state_reg.mRdata;
  assign sReq = state_reg.sReq;
  assign sAddr = state_reg.sAddr;
  assign sWrite = state_reg.sWrite;
  assign sWdata = state_reg.sWdata;
  // Instantiate once per processing channel; nothing here is global.
endmodule : xbs_crossbar_switch

// ---- xbs_pkg.sv ----
// Constants, types and the address decode for the crossbar switch.
// Assumes one clock and one reset shared by every user of the package.
package xbs_pkg;
  localparam int XBS_NUM_M = 4;
  localparam int XBS_NUM_S = 3;
  localparam int XBS_ADDR_W = 32;
  localparam int XBS_DATA_W = 64;
  // Master port assignment.
  localparam logic [1:0] XBS_M_INSTR = 2'h0;
  localparam logic [1:0] XBS_M_DATA = 2'h1;
  localparam logic [1:0] XBS_M_DMA = 2'h2;
  localparam logic [1:0] XBS_M_NET = 2'h3;
  // Slave port assignment and address regions on bits 31:28.
  localparam logic [1:0] XBS_S_FLASH = 2'h0;
  localparam logic [1:0] XBS_S_SRAM = 2'h1;
  localparam logic [1:0] XBS_S_BRIDGE = 2'h2;
  localparam int XBS_REGION_LSB = 28;
  localparam logic [3:0] XBS_FLASH_REGION = 4'h0;
  localparam logic [3:0] XBS_SRAM_REGION = 4'h4;
  // Values after reset.
  localparam logic [1:0] XBS_RST_ID = 2'h0;
  localparam logic [XBS_DATA_W-1:0] XBS_RST_DATA = 64'h0;
  localparam logic [XBS_ADDR_W-1:0] XBS_RST_ADDR = 32'h0;

  typedef enum logic [1:0] {
    XBS_IDLE = 2'b00,
    XBS_ISSUE = 2'b01,
    XBS_RESP = 2'b10
  } xbs_slv_state_t;

  function automatic logic [1:0] xbsDecode(input logic [XBS_ADDR_W-1:0] a);
    logic [3:0] region;
    region = a[XBS_REGION_LSB +: 4];
    if (region == XBS_FLASH_REGION) begin
      xbsDecode = XBS_S_FLASH;
    end else if (region == XBS_SRAM_REGION) begin
      xbsDecode = XBS_S_SRAM;
    end else begin
      xbsDecode = XBS_S_BRIDGE;
    end
  endfunction : xbsDecode
endpackage : xbs_pkg

// ---- xbs_arb_if.sv ----
// Carrier between the switch and one per-slave arbiter.
// Assumes the switch drives requests and the arbiter answers combinationally.
`timescale 1ns/1ps
interface xbs_arb_if;
  import xbs_pkg::*;
  logic [XBS_NUM_M-1:0] req;
  logic [XBS_NUM_M-1:0] elevate;
  logic [XBS_NUM_M-1:0][1:0] prio;
  logic rrMode;
  logic [1:0] lastId;
  logic [1:0] grantId;
  logic grantValid;
  modport arb (
    input req, elevate, prio, rrMode, lastId,
    output grantId, grantValid
  );
  modport sw (
    output req, elevate, prio, rrMode, lastId,
    input grantId, grantValid
  );
endinterface : xbs_arb_if

// ---- xbs_arbiter.sv ----
// Arbiter for one slave port: picks one master from the requesters.
// Assumes inputs are stable in the cycle; it holds no state of its own.
`timescale 1ns/1ps
module xbs_arbiter
  import xbs_pkg::*;
(
  // Request and grant.
  xbs_arb_if.arb bus
);
  logic [XBS_NUM_M-1:0] pool;
  logic [1:0] fixId;
  logic [1:0] rrId;

  always_comb begin
    // Elevated requesters shadow all others while they ask.
    if ((bus.req & bus.elevate) != '0) begin
      pool = bus.req & bus.elevate;
    end else begin
      pool = bus.req;
    end
    // Round robin starts after the last master granted here.
    rrId = bus.lastId;
    for (int k = XBS_NUM_M; k >= 1; k--) begin
      if (pool[2'(bus.lastId + 2'(k))]) begin
        rrId = 2'(bus.lastId + 2'(k));
      end
    end
    // Fixed order: higher level wins, the lower index breaks a tie.
    fixId = XBS_RST_ID;
    for (int m = XBS_NUM_M - 1; m >= 0; m--) begin
      if (pool[m] && (!pool[fixId] || bus.prio[m] >= bus.prio[fixId])) begin
        fixId = 2'(m);
      end
    end
    bus.grantValid = (pool != '0);
    bus.grantId = bus.rrMode ? rrId : fixId;
  end
endmodule : xbs_arbiter

// ---- xbs_crossbar_switch_asserts.sv ----
// Port checker for the crossbar switch, bound to every switch instance.
// Assumes one clock and the switch's own active-high reset.
`timescale 1ns/1ps
module xbs_crossbar_switch_chk
  import xbs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Watched ports.
  input wire logic [XBS_NUM_M-1:0] mReq,
  input wire logic [XBS_NUM_M-1:0] mReady,
  input wire logic [XBS_NUM_S-1:0] sReq,
  input wire logic [XBS_NUM_S-1:0][XBS_ADDR_W-1:0] sAddr,
  input wire logic [XBS_NUM_S-1:0] sReady
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_ready_pulse: assert property (mReady != 0 |=> (mReady & $past(mReady)) == 0) else $error("ready too long");
  a_ready_has_req: assert property (mReady != 0 |-> ($past(mReq) & mReady) == mReady) else $error("ready without request");
  a_ready_cause: assert property (mReady != 0 |-> $past(sReq & sReady) != 0) else $error("ready without slave");
  a_ready_count: assert property ((sReq & sReady) != 0 |=> $countones(mReady) == $countones($past(sReq & sReady))) else $error("ready lost");
  a_sreq_hold: assert property ((sReq & ~sReady) != 0 |=> ($past(sReq & ~sReady) & ~sReq) == 0) else $error("request dropped");
  a_sreq_drop: assert property ((sReq & sReady) != 0 |=> ($past(sReq & sReady) & sReq) == 0) else $error("request kept");
  a_addr_stable: assert property (sReq[1] && !sReady[1] |=> $stable(sAddr[1])) else $error("address moved");
  a_flash_route: assert property ($rose(sReq[0]) |-> sAddr[0][31:28] == 4'h0) else $error("bad flash route");
  a_issue_cause: assert property ((sReq & ~$past(sReq)) != 0 |-> $past(mReq) != 0) else $error("issue without master");
endmodule : xbs_crossbar_switch_chk

bind xbs_crossbar_switch xbs_crossbar_switch_chk u_chk (
  .clk_sys(clk_sys), .rst(rst), .mReq(mReq), .mReady(mReady),
  .sReq(sReq), .sAddr(sAddr), .sReady(sReady)
);

// ---- xbs_slave_model.sv ----
// Behavioural slave controller answering one switch slave port.
// Assumes the switch holds its request until it has seen ready.
`timescale 1ns/1ps
module xbs_slave_model
  import xbs_pkg::*;
#(
  parameter int LAT = 0
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Switch side.
  input wire logic sReq,
  input wire logic [XBS_ADDR_W-1:0] sAddr,
  input wire logic sWrite,
  input wire logic [XBS_DATA_W-1:0] sWdata,
  output logic sReady,
  output logic [XBS_DATA_W-1:0] sRdata
);
  int cnt;
  // Idle read data toggles every cycle so stale data never looks valid.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sReady <= 1'b0;
      sRdata <= 64'h0;
      cnt <= 0;
    end else if (!sReady && sReq && cnt >= LAT) begin
      sReady <= 1'b1;
      // A write answers with the data it carried, exposing the write path.
      sRdata <= sWrite ? sWdata : {sAddr, ~sAddr};
      cnt <= 0;
    end else begin
      sReady <= 1'b0;
      sRdata <= ~sRdata;
      cnt <= (sReq && !sReady) ? cnt + 1 : 0;
    end
  end
endmodule : xbs_slave_model

// ---- tb_top.sv ----
// Self-checking bench for the crossbar switch with three slave models.
// Assumes masters hold requests until their ready pulse.
`timescale 1ns/1ps
module tb_top
  import xbs_pkg::*;
;
  logic clk_sys = 0, rst = 1, rrMode = 0;
  logic [3:0][1:0] mPrio = '0;
  logic [3:0] mElevate = '0, mReq = '0, mReady, fin;
  logic [3:0] mWrite = '0, mLock = '0, again = '0;
  logic [3:0][63:0] mWdata = '0;
  logic [63:0] want;
  logic [3:0][31:0] mAddr = '0;
  logic [3:0][63:0] mRdata;
  logic [2:0] sReq, sReady, sWrite;
  logic [2:0][31:0] sAddr;
  logic [2:0][63:0] sRdata, sWdata;
  logic [1:0] order[$];
  int bad_count = 0, n_checks = 0;
  xbs_crossbar_switch u_dut (.clk_sys(clk_sys), .rst(rst), .rrMode(rrMode),
    .mPrio(mPrio), .mElevate(mElevate), .mReq(mReq), .mAddr(mAddr),
    .mWrite(mWrite), .mWdata(mWdata), .mLock(mLock), .mReady(mReady),
    .mRdata(mRdata), .sReq(sReq), .sAddr(sAddr), .sWrite(sWrite),
    .sWdata(sWdata), .sReady(sReady), .sRdata(sRdata));
  // Flash is slowest so parallel paths issued together finish bridge first, then SRAM, then flash.
  for (genvar s = 0; s < 3; s++) begin : g_slv
    xbs_slave_model #(.LAT(s == 0 ? 3 : 2 - s)) u_slv (.clk_sys(clk_sys),
      .rst(rst), .sReq(sReq[s]), .sAddr(sAddr[s]), .sWrite(sWrite[s]),
      .sWdata(sWdata[s]), .sReady(sReady[s]),
      .sRdata(sRdata[s]));
  end
  initial forever #5 clk_sys = ~clk_sys;
  task automatic summarize;
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic chk_id(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: master %0d done, want %0d", $time, got, exp);
    end
  endtask : chk_id
  task automatic chk_data(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: read data %h", $time, got);
    end
  endtask : chk_data
  task automatic chk_count(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %0d done, want %0d", $time, got, exp);
    end
  endtask : chk_count
  always @(posedge clk_sys) begin
    fin = mReady;
    for (int i = 0; i < 4; i++) begin
      if (fin[i] === 1'b1) begin
        order.push_back(i[1:0]);
        want = mWrite[i] ? mWdata[i] : {mAddr[i], ~mAddr[i]};
        chk_data(mRdata[i], want);
      end
    end
    #1;
    if (fin != 4'h0) begin
      mReq = (mReq & ~fin) | (fin & again);
      again = again & ~fin;
    end
  end
  task automatic run(input logic [3:0] req, input logic [3:0][31:0] a,
      input logic [1:0] exp[$]);
    order.delete();
    @(posedge clk_sys);
    #1 mAddr = a;
    mReq = req;
    for (int k = 0; k < 50 && mReq !== 4'h0; k++) @(posedge clk_sys);
    #1;
    chk_count(8'(order.size()), 8'(exp.size()));
    for (int k = 0; k < exp.size(); k++) chk_id(order[k], exp[k]);
  endtask : run
  task automatic t_parallel;
    run(4'h7, '{32'h0, 32'h8000_0020, 32'h4000_0010, 32'h100}, '{2, 1, 0});
  endtask : t_parallel
  task automatic t_fixed;
    mPrio = '{2'h0, 2'h3, 2'h0, 2'h0};
    run(4'h6, '{32'h0, 32'h4000_0008, 32'h4000_0018, 32'h0}, '{2, 1});
  endtask : t_fixed
  task automatic t_elevate;
    mPrio = '{2'h0, 2'h0, 2'h3, 2'h0};
    mElevate = 4'h4;
    run(4'h6, '{32'h0, 32'h4000_0030, 32'h4000_0038, 32'h0}, '{2, 1});
    mElevate = 4'h0;
    run(4'h6, '{32'h0, 32'h4000_0040, 32'h4000_0048, 32'h0}, '{1, 2});
  endtask : t_elevate
  task automatic t_round;
    rrMode = 1'b1;
    mPrio = '0;
    run(4'hb, '{32'h9000_0000, 32'h0, 32'h9000_0008, 32'h9000_0010}, '{3, 0, 1});
  endtask : t_round
  task automatic t_lock;
    // Round robin alone would pass the port to master 2 after master 1,
    // so a second turn for master 1 can only come from the lock.
    rrMode = 1'b1;
    mLock = 4'h2;
    mWrite = 4'h2;
    mWdata[1] = 64'h0123_4567_89ab_cdef;
    again = 4'h2;
    run(4'h6, '{32'h0, 32'h4000_0050, 32'h4000_0058, 32'h0}, '{1, 1, 2});
    mLock = 4'h0;
    mWrite = 4'h0;
  endtask : t_lock
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 rst = 1'b0;
    t_parallel();
    t_fixed();
    t_elevate();
    t_round();
    t_lock();
    summarize();
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end
endmodule : tb_top
